// ### logic/tmon_pkg.sv
package tmon_pkg;

  // ------------------------------------------------------------------
  // Channels, in conversion order
  // ------------------------------------------------------------------
  localparam int NUM_CH = 6;
  localparam int CH_W = 3;
  localparam logic [2:0] CH_REM1 = 3'h0;
  localparam logic [2:0] CH_REM2 = 3'h1;
  localparam logic [2:0] CH_GEN8 = 3'h2;
  localparam logic [2:0] CH_GEN9 = 3'h3;
  localparam logic [2:0] CH_VBAT = 3'h4;
  localparam logic [2:0] CH_LOCAL = 3'h5;

  // ------------------------------------------------------------------
  // Averaging and timing
  // ------------------------------------------------------------------
  localparam int ACC_W = 12;
  localparam int AVG_SH = 4;
  localparam logic [3:0] AVG_LAST = 4'hF;
  localparam int CLK_NS = 5;
  localparam int CONV_NS = 711000;
  localparam int REMOTE_NS = 2140000;

  // ------------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------------
  localparam logic [7:0] ADDR_CFG1 = 8'h00;
  localparam logic [7:0] ADDR_CFG3 = 8'h07;
  localparam logic [7:0] ADDR_REM1 = 8'h1E;
  localparam logic [7:0] ADDR_LOCAL = 8'h1F;
  localparam logic [7:0] ADDR_STATUS = 8'h20;
  localparam logic [7:0] ADDR_VBAT = 8'h26;
  localparam logic [7:0] ADDR_GEN8 = 8'h27;
  localparam logic [7:0] ADDR_PAIR = 8'h29;
  localparam logic [7:0] ADDR_HI_BASE = 8'h40;
  localparam logic [7:0] ADDR_LO_BASE = 8'h50;
  localparam int CFG1_START = 0;
  localparam int CFG1_PAIR_AIN = 3;
  localparam int CFG3_REF_HI = 2;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [7:0] TEMP_HI_RST = 8'h7F;
  localparam logic [7:0] TEMP_LO_RST = 8'h80;
  localparam logic [7:0] VOLT_HI_RST = 8'hFF;
  localparam logic [7:0] VOLT_LO_RST = 8'h00;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_PH_A = 3'b010,
    ST_PH_B = 3'b100
  } tmon_state_t;

  function automatic logic tmon_is_temp(input logic [2:0] ch);
    return (ch == CH_REM1) || (ch == CH_REM2) || (ch == CH_LOCAL);
  endfunction

endpackage

// ### logic/tmon_readout.sv
// Overview of operation
// - Battery divider lower leg connected only during a battery conversion.
// - Channels converted round-robin; each stored reading except battery averages 16 conversions.
// - Battery channel stores one unaveraged conversion of one conversion period.
// - Third config register bit 2 selects reference level: 0 low, 1 high.
// - Each on-chip temperature result is written to the value register at 1Fh.
// - Temperatures are 8-bit twos complement, one degree per step.
// - First config register bit 3: 0 second diode pair, 1 analog inputs.
// - First remote diode channel is always a temperature input.
// - Remote bias alternates between base and multiple current; result is difference.
// - Remote temperature reported as 8-bit twos complement average of 16 cycles.
// - One remote measurement takes nominally 2.14 ms.
// - Voltage channels hold high and low limits; violation requests interrupt.
// - Temperature alarm sets above hot limit, clears below lower limit.
// - Start bit 0 of first config register runs cycling; clearing stops it.
// - Cycle starts with first remote channel and ends with local temperature.
// - Shared pair converted both ways; diode result to 29h, 27h then invalid.
module tmon_readout #(
  parameter int TMR_W = 20,
  parameter int CONV_CYC = tmon_pkg::CONV_NS / tmon_pkg::CLK_NS,
  parameter int REMOTE_CYC = tmon_pkg::REMOTE_NS / tmon_pkg::CLK_NS
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // Converter front end
  input wire logic [7:0] conv_data_i,
  output logic [2:0] conv_chan_o,
  output logic bias_high_o,
  output logic vbat_div_en_o,
  // Pin function and status
  output logic ref_sel_2v5_o,
  output logic pair_ain_mode_o,
  output logic alarm_o
);

  localparam logic [TMR_W-1:0] CONV_LAST = TMR_W'(CONV_CYC - 1);
  localparam logic [TMR_W-1:0] REM_LAST = TMR_W'(REMOTE_CYC / 2 - 1);

  // ------------------------------------------------------------------
  // Reset release
  // ------------------------------------------------------------------
  logic rst_meta_q, rst_sync_q;
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // ------------------------------------------------------------------
  // Conversion sequencer
  // ------------------------------------------------------------------
  tmon_pkg::tmon_state_t state_q, state_d;
  logic [2:0] ch_q, ch_d, sch_q, sch_d;
  logic [3:0] cnt_q, cnt_d;
  logic [TMR_W-1:0] tmr_q, tmr_d;
  logic [tmon_pkg::ACC_W-1:0] acc_q, acc_d, sum;
  logic [7:0] lowv_q, lowv_d, sval_q, sval_d, samp;
  logic store_q, store_d, fin, is_rem, start;
  logic div_q, div_d, bias_q, bias_d;
  logic [7:0] cfg1_q, cfg3_q;

  assign start = cfg1_q[tmon_pkg::CFG1_START];

  always_comb begin
    state_d = state_q;
    ch_d = ch_q;
    cnt_d = cnt_q;
    tmr_d = tmr_q + 1'b1;
    acc_d = acc_q;
    lowv_d = lowv_q;
    store_d = 1'b0;
    sval_d = sval_q;
    sch_d = sch_q;
    samp = 8'h00;
    fin = 1'b0;
    sum = acc_q;
    // The first remote pair is a diode channel whatever the config says.
    is_rem = (ch_q == tmon_pkg::CH_REM1) || (ch_q == tmon_pkg::CH_REM2);
    case (state_q)
      tmon_pkg::ST_IDLE: begin
        tmr_d = '0;
        if (start) begin
          state_d = tmon_pkg::ST_PH_A;
          ch_d = tmon_pkg::CH_REM1;
          cnt_d = 4'h0;
          acc_d = '0;
        end
      end
      tmon_pkg::ST_PH_A: begin
        // Remote measurements split the slot into two bias halves.
        if (is_rem && tmr_q == REM_LAST) begin
          lowv_d = conv_data_i;
          tmr_d = '0;
          state_d = tmon_pkg::ST_PH_B;
        end else if (!is_rem && tmr_q == CONV_LAST) begin
          samp = conv_data_i;
          fin = 1'b1;
        end
      end
      tmon_pkg::ST_PH_B: begin
        if (tmr_q == REM_LAST) begin
          samp = conv_data_i - lowv_q;
          fin = 1'b1;
        end
      end
      default: state_d = tmon_pkg::ST_IDLE;
    endcase
    if (fin) begin
      // Temperatures are signed and extended as such; voltages are not.
      if (tmon_pkg::tmon_is_temp(ch_q)) begin
        sum = acc_q + {{(tmon_pkg::ACC_W - 8){samp[7]}}, samp};
      end else begin
        sum = acc_q + {{(tmon_pkg::ACC_W - 8){1'b0}}, samp};
      end
      tmr_d = '0;
      state_d = tmon_pkg::ST_PH_A;
      if (ch_q == tmon_pkg::CH_VBAT || cnt_q == tmon_pkg::AVG_LAST) begin
        store_d = 1'b1;
        sch_d = ch_q;
        // Battery keeps one raw sample to shorten the drain window.
        sval_d = (ch_q == tmon_pkg::CH_VBAT) ? samp : sum[tmon_pkg::AVG_SH +: 8];
        ch_d = (ch_q == tmon_pkg::CH_LOCAL) ? tmon_pkg::CH_REM1 : ch_q + 3'h1;
        cnt_d = 4'h0;
        acc_d = '0;
      end else begin
        cnt_d = cnt_q + 4'h1;
        acc_d = sum;
      end
    end
    if (!start) state_d = tmon_pkg::ST_IDLE;
    // Divider leg only while the single battery conversion runs.
    div_d = (state_d != tmon_pkg::ST_IDLE) && (ch_d == tmon_pkg::CH_VBAT);
    bias_d = (state_d == tmon_pkg::ST_PH_B);
  end

  always_ff @(posedge clk_sys_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      state_q <= tmon_pkg::ST_IDLE;
      ch_q <= tmon_pkg::CH_REM1;
      cnt_q <= 4'h0;
      tmr_q <= '0;
      acc_q <= '0;
      lowv_q <= 8'h00;
      store_q <= 1'b0;
      sval_q <= 8'h00;
      sch_q <= tmon_pkg::CH_REM1;
      div_q <= 1'b0;
      bias_q <= 1'b0;
      conv_chan_o <= tmon_pkg::CH_REM1;
    end else begin
      state_q <= state_d;
      ch_q <= ch_d;
      cnt_q <= cnt_d;
      tmr_q <= tmr_d;
      acc_q <= acc_d;
      lowv_q <= lowv_d;
      store_q <= store_d;
      sval_q <= sval_d;
      sch_q <= sch_d;
      div_q <= div_d;
      bias_q <= bias_d;
      conv_chan_o <= ch_d;
    end
  end

  assign vbat_div_en_o = div_q;
  assign bias_high_o = bias_q;

  // ------------------------------------------------------------------
  // Per-channel values, limits and flags
  // ------------------------------------------------------------------
  logic [7:0] val_q [tmon_pkg::NUM_CH];
  logic [7:0] hi_q [tmon_pkg::NUM_CH];
  logic [7:0] lo_q [tmon_pkg::NUM_CH];
  logic [tmon_pkg::NUM_CH-1:0] stat_q, talm_q, stat_d;
  logic pair_ain;

  assign pair_ain = cfg1_q[tmon_pkg::CFG1_PAIR_AIN];

  for (genvar g = 0; g < tmon_pkg::NUM_CH; g++) begin : g_ch
    localparam logic [2:0] CH = 3'(g);
    localparam logic TEMP = tmon_pkg::tmon_is_temp(CH);
    localparam logic [7:0] HA = tmon_pkg::ADDR_HI_BASE + 8'(g);
    localparam logic [7:0] LA = tmon_pkg::ADDR_LO_BASE + 8'(g);
    logic [7:0] val_d, hi_d, lo_d;
    logic talm_d, valid, hit, vhi, vlo, clr;
    always_comb begin
      // Only the reading that matches the pair's function is live.
      valid = 1'b1;
      if (CH == tmon_pkg::CH_REM2) begin
        valid = !pair_ain;
      end else if (CH == tmon_pkg::CH_GEN8 || CH == tmon_pkg::CH_GEN9) begin
        valid = pair_ain;
      end
      hit = store_q && (sch_q == CH) && valid;
      vhi = TEMP ? $signed(sval_q) > $signed(hi_q[g]) : sval_q > hi_q[g];
      vlo = TEMP ? $signed(sval_q) < $signed(lo_q[g]) : sval_q < lo_q[g];
      val_d = hit ? sval_q : val_q[g];
      hi_d = (reg_wr_i && reg_addr_i == HA) ? reg_wdata_i : hi_q[g];
      lo_d = (reg_wr_i && reg_addr_i == LA) ? reg_wdata_i : lo_q[g];
      // Hot alarm holds until the reading drops below the lower limit.
      talm_d = talm_q[g];
      if (hit && TEMP && vhi) begin
        talm_d = 1'b1;
      end else if (hit && TEMP && vlo) begin
        talm_d = 1'b0;
      end
      clr = reg_wr_i && reg_addr_i == tmon_pkg::ADDR_STATUS && reg_wdata_i[g];
      // A violation in the clearing cycle survives the clear.
      stat_d[g] = (stat_q[g] && !clr) || (hit && (vhi || (vlo && !TEMP)));
    end
    always_ff @(posedge clk_sys_i or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
        val_q[g] <= 8'h00;
        hi_q[g] <= TEMP ? tmon_pkg::TEMP_HI_RST : tmon_pkg::VOLT_HI_RST;
        lo_q[g] <= TEMP ? tmon_pkg::TEMP_LO_RST : tmon_pkg::VOLT_LO_RST;
        talm_q[g] <= 1'b0;
        stat_q[g] <= 1'b0;
      end else begin
        val_q[g] <= val_d;
        hi_q[g] <= hi_d;
        lo_q[g] <= lo_d;
        talm_q[g] <= talm_d;
        stat_q[g] <= stat_d[g];
      end
    end
  end

  // ------------------------------------------------------------------
  // Configuration and read port
  // ------------------------------------------------------------------
  logic [7:0] cfg1_d, cfg3_d, rdata_d;
  logic alarm_d;
  localparam logic [tmon_pkg::NUM_CH-1:0] VOLT_MASK = 6'h1C;

  always_comb begin
    cfg1_d = cfg1_q;
    cfg3_d = cfg3_q;
    if (reg_wr_i && reg_addr_i == tmon_pkg::ADDR_CFG1) begin
      cfg1_d = reg_wdata_i;
    end
    if (reg_wr_i && reg_addr_i == tmon_pkg::ADDR_CFG3) begin
      cfg3_d = reg_wdata_i;
    end
    rdata_d = reg_rdata_o;
    if (reg_rd_i) begin
      rdata_d = 8'h00;
      case (reg_addr_i)
        tmon_pkg::ADDR_CFG1: rdata_d = cfg1_q;
        tmon_pkg::ADDR_CFG3: rdata_d = cfg3_q;
        tmon_pkg::ADDR_REM1: rdata_d = val_q[tmon_pkg::CH_REM1];
        tmon_pkg::ADDR_LOCAL: rdata_d = val_q[tmon_pkg::CH_LOCAL];
        tmon_pkg::ADDR_VBAT: rdata_d = val_q[tmon_pkg::CH_VBAT];
        tmon_pkg::ADDR_STATUS: rdata_d = {2'b00, stat_q};
        // In diode mode 27h has no valid result and reads zero.
        tmon_pkg::ADDR_GEN8: rdata_d = pair_ain ? val_q[tmon_pkg::CH_GEN8] : 8'h00;
        tmon_pkg::ADDR_PAIR: begin
          rdata_d = pair_ain ? val_q[tmon_pkg::CH_GEN9] : val_q[tmon_pkg::CH_REM2];
        end
        default: begin
          for (int i = 0; i < tmon_pkg::NUM_CH; i++) begin
            if (reg_addr_i == tmon_pkg::ADDR_HI_BASE + 8'(i)) begin
              rdata_d = hi_q[i];
            end
            if (reg_addr_i == tmon_pkg::ADDR_LO_BASE + 8'(i)) begin
              rdata_d = lo_q[i];
            end
          end
        end
      endcase
    end
    alarm_d = |(stat_d & VOLT_MASK) || |talm_q;
  end

  always_ff @(posedge clk_sys_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      cfg1_q <= tmon_pkg::CFG_RST;
      cfg3_q <= tmon_pkg::CFG_RST;
      reg_rdata_o <= 8'h00;
      ref_sel_2v5_o <= 1'b0;
      pair_ain_mode_o <= 1'b0;
      alarm_o <= 1'b0;
    end else begin
      cfg1_q <= cfg1_d;
      cfg3_q <= cfg3_d;
      reg_rdata_o <= rdata_d;
      ref_sel_2v5_o <= cfg3_d[tmon_pkg::CFG3_REF_HI];
      pair_ain_mode_o <= cfg1_d[tmon_pkg::CFG1_PAIR_AIN];
      alarm_o <= alarm_d;
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_sync_q);

  a_div_only_vbat: assert property (
    vbat_div_en_o |-> ch_q == tmon_pkg::CH_VBAT && state_q != tmon_pkg::ST_IDLE)
    else $error("divider connected outside battery conversion");
  a_div_one_conv: assert property ($fell(vbat_div_en_o) |-> !$past(start) || store_q)
    else $error("divider dropped without battery store");
  a_avg_count: assert property (store_d && ch_q != tmon_pkg::CH_VBAT |-> cnt_q == 4'hF)
    else $error("stored before sixteen conversions");
  a_vbat_raw: assert property (
    store_d && ch_q == tmon_pkg::CH_VBAT |=> sval_q == $past(samp))
    else $error("battery value not the raw sample");
  a_ref_follow: assert property (
    $changed(cfg3_q) |-> ref_sel_2v5_o == cfg3_q[tmon_pkg::CFG3_REF_HI])
    else $error("reference select does not follow config");
  a_local_store: assert property (
    store_q && sch_q == tmon_pkg::CH_LOCAL |=> val_q[tmon_pkg::CH_LOCAL] == $past(sval_q))
    else $error("local result not stored");
  a_stop_idle: assert property (!start |=> state_q == tmon_pkg::ST_IDLE && !vbat_div_en_o)
    else $error("cycling continued after stop");
  a_first_chan: assert property (state_q == tmon_pkg::ST_IDLE && start |=> ch_q == 3'h0)
    else $error("cycle did not begin with first remote");
  a_bias_remote: assert property (bias_high_o |-> ch_q <= tmon_pkg::CH_REM2)
    else $error("bias toggled on non-remote channel");
  a_volt_limit: assert property (
    store_q && sch_q == tmon_pkg::CH_GEN8 && pair_ain && sval_q > hi_q[tmon_pkg::CH_GEN8]
    |=> stat_q[tmon_pkg::CH_GEN8])
    else $error("voltage limit violation not flagged");

endmodule // tmon_readout

// ### test/tmon_diode_cell_model.sv
module tmon_diode_cell_model #(
  parameter logic [7:0] REM_BASE = 8'h40,
  parameter logic [7:0] REM1_T = 8'h19,
  parameter logic [7:0] REM2_T = 8'hF6,
  parameter logic [7:0] GEN8_V = 8'hA5,
  parameter logic [7:0] GEN9_V = 8'h3C,
  parameter logic [7:0] VBAT_V = 8'hC0,
  parameter logic [7:0] LOCAL_T = 8'hE7
) (
  // Front-end controls
  input wire logic [2:0] conv_chan_i,
  input wire logic bias_high_i,
  input wire logic vbat_div_en_i,
  // Converted value
  output logic [7:0] conv_data_o
);
  timeunit 1ns;
  timeprecision 100ps;

  // The diode shows only its delta: low bias gives the base, high bias adds the temperature.
  always_comb begin
    case (conv_chan_i)
      tmon_pkg::CH_REM1: conv_data_o = bias_high_i ? REM_BASE + REM1_T : REM_BASE;
      tmon_pkg::CH_REM2: conv_data_o = bias_high_i ? REM_BASE + REM2_T : REM_BASE;
      tmon_pkg::CH_GEN8: conv_data_o = GEN8_V;
      tmon_pkg::CH_GEN9: conv_data_o = GEN9_V;
      // Without the lower leg the divider reads garbage, shown as the inverse.
      tmon_pkg::CH_VBAT: conv_data_o = vbat_div_en_i ? VBAT_V : ~VBAT_V;
      default: conv_data_o = LOCAL_T;
    endcase
  end
endmodule // tmon_diode_cell_model

// ### test/tb_tmon_readout.sv
module tb_tmon_readout;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int CONV = 8;
  localparam int REM = 16;
  localparam logic [7:0] T_ADDR [13] = '{8'h00, 8'h07, 8'h45, 8'h55, 8'h42, 8'h52,
    8'h1E, 8'h29, 8'h27, 8'h26, 8'h1F, 8'h20, 8'h3F};
  localparam logic [7:0] T_EXP [13] = '{8'h00, 8'h00, 8'h7F, 8'h80, 8'hFF, 8'h00,
    8'h19, 8'hF6, 8'h00, 8'hC0, 8'hE7, 8'h00, 8'h00};
  logic clk_sys_i = 0;
  logic rst_n_i = 0;
  logic [7:0] reg_addr_i = 0;
  logic [7:0] reg_wdata_i = 0;
  logic reg_wr_i = 0;
  logic reg_rd_i = 0;
  logic [7:0] reg_rdata_o, conv_data_i, rv;
  logic [2:0] conv_chan_o, prev_ch, ch_s;
  logic bias_high_o, vbat_div_en_o, ref_sel_2v5_o, pair_ain_mode_o, alarm_o, bad;
  logic mon_en = 0;
  int error_cnt = 0;
  int n_compared = 0;
  int div_cnt = 0;
  int hi_cnt = 0;

  tmon_readout #(.CONV_CYC(CONV), .REMOTE_CYC(REM)) dut (.clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .conv_data_i(conv_data_i), .conv_chan_o(conv_chan_o), .bias_high_o(bias_high_o),
    .vbat_div_en_o(vbat_div_en_o), .ref_sel_2v5_o(ref_sel_2v5_o),
    .pair_ain_mode_o(pair_ain_mode_o), .alarm_o(alarm_o));

  tmon_diode_cell_model model (.conv_chan_i(conv_chan_o), .bias_high_i(bias_high_o),
    .vbat_div_en_i(vbat_div_en_o), .conv_data_o(conv_data_i));

  initial begin
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end

  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic close_out;
    if (error_cnt == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    #1;
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1;
    @(posedge clk_sys_i);
    #1;
    reg_wr_i = 0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys_i);
    #1;
    reg_addr_i = a;
    reg_rd_i = 1;
    @(posedge clk_sys_i);
    #1;
    reg_rd_i = 0;
    @(posedge clk_sys_i);
    #1;
    d = reg_rdata_o;
  endtask

  task automatic run_rows(input int lo, input int hi);
    logic [7:0] v;
    for (int i = lo; i <= hi; i++) begin
      rd(T_ADDR[i], v);
      chk("row", v, T_EXP[i]);
    end
  endtask

  // Returns just after the local channel hands over to the next round.
  task automatic wait_round;
    int i;
    logic s5;
    s5 = 0;
    for (i = 0; i < 4000 && !(s5 && conv_chan_o !== tmon_pkg::CH_LOCAL); i++) begin
      @(posedge clk_sys_i);
      #1;
      if (conv_chan_o === tmon_pkg::CH_LOCAL) s5 = 1;
    end
    if (i == 4000) begin
      error_cnt++;
      close_out();
    end
    repeat (4) @(posedge clk_sys_i);
  endtask

  // ------------------------------------------------------------------
  // Front-end monitor
  // ------------------------------------------------------------------
  always @(posedge clk_sys_i) begin
    if (mon_en) begin
      // Counters restart on the channel change before the new slot's first cycle is counted.
      if (conv_chan_o !== prev_ch) begin
        chk("order", {5'h00, conv_chan_o}, {5'h00, (prev_ch == tmon_pkg::CH_LOCAL) ?
          tmon_pkg::CH_REM1 : prev_ch + 3'h1});
        if (prev_ch == tmon_pkg::CH_VBAT)
          chk("div_len", 8'(div_cnt), 8'(CONV));
        if (prev_ch == tmon_pkg::CH_REM1 || prev_ch == tmon_pkg::CH_REM2)
          chk("bias_len", 8'(hi_cnt), 8'(16 * REM / 2));
        div_cnt = 0;
        hi_cnt = 0;
      end
      if (vbat_div_en_o === 1'b1) begin
        div_cnt++;
        chk("div_chan", {5'h00, conv_chan_o}, {5'h00, tmon_pkg::CH_VBAT});
      end
      if (bias_high_o === 1'b1) hi_cnt++;
      prev_ch = conv_chan_o;
    end else begin
      prev_ch = 3'h0;
      div_cnt = 0;
      hi_cnt = 0;
    end
  end

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk_sys_i);
    #1;
    rst_n_i = 1;
    repeat (4) @(posedge clk_sys_i);
    run_rows(0, 5);
    wr(8'h07, 8'h04);
    chk("ref_sel", {7'h00, ref_sel_2v5_o}, 8'h01);
    mon_en = 1;
    wr(8'h00, 8'h01);
    wait_round();
    run_rows(6, 12);
    // Hot limit below the local reading raises the alarm.
    wr(8'h45, 8'hE0);
    wait_round();
    chk("alarm_hot", {7'h00, alarm_o}, 8'h01);
    rd(8'h20, rv);
    chk("status_hot", rv, 8'h20);
    wr(8'h55, 8'hF0);
    wr(8'h20, 8'h20);
    wr(8'h45, 8'h7F);
    wait_round();
    chk("alarm_clr", {7'h00, alarm_o}, 8'h00);
    // Shared pair as analog inputs with a violated voltage high limit.
    wr(8'h42, 8'h80);
    wr(8'h00, 8'h09);
    chk("pair_mode", {7'h00, pair_ain_mode_o}, 8'h01);
    wait_round();
    wait_round();
    rd(8'h27, rv);
    chk("gen8", rv, 8'hA5);
    rd(8'h29, rv);
    chk("gen9", rv, 8'h3C);
    rd(8'h20, rv);
    chk("status_v", rv, 8'h04);
    chk("alarm_v", {7'h00, alarm_o}, 8'h01);
    // Clearing start freezes the sequencer.
    mon_en = 0;
    wr(8'h00, 8'h00);
    repeat (3) @(posedge clk_sys_i);
    #1;
    ch_s = conv_chan_o;
    bad = 0;
    repeat (300) begin
      @(posedge clk_sys_i);
      #1;
      if (conv_chan_o !== ch_s || vbat_div_en_o !== 1'b0 || bias_high_o !== 1'b0) bad = 1;
    end
    chk("stopped", {7'h00, bad}, 8'h00);
    // A second reset in mid-run clears outputs and configuration.
    wr(8'h00, 8'h01);
    repeat (100) @(posedge clk_sys_i);
    #1;
    rst_n_i = 0;
    repeat (2) @(posedge clk_sys_i);
    #1;
    chk("rst_out", {1'b0, conv_chan_o, bias_high_o, vbat_div_en_o, ref_sel_2v5_o,
      pair_ain_mode_o}, 8'h00);
    rst_n_i = 1;
    repeat (4) @(posedge clk_sys_i);
    run_rows(0, 5);
    close_out();
  end
endmodule // tb_tmon_readout
